// ---- include/tpc_pkg.sv ----
// Purpose: Shared constants for the test port and PRBS control block.
// Assumes: 8-bit register bus, byte offsets as printed.
// Notes:   Every offset, field position, reset value and code lives here.
//
// What this block does
// - Swap bit set: test bus goes to parallel port in permuted order.
// - Nine-stage PRBS bit arms NINE_STAGE_PRBS_ENABLE; Transmit command starts sending it.
// - Fifteen-stage PRBS bit arms FIFTEEN_STAGE_PRBS_ENABLE; Transmit command starts sending it.
// - Low five bits of test-select choose the routed probe group.
// - UART line enable at bit 7 low disables both auxiliary UART lines.
// - Drive enable bits 6..1 switch on drivers of pins D6..D1.
// - With SPI host, only pins D1 to D4 serve as test or I/O.
// - With UART host and UART lines on, only D1 to D4 usable.
// - I/O mode bit with serial host makes test port general I/O.
// - In I/O mode level bits set pin levels on enabled pins only.
// - I/O mode on: pin-level read returns live pins D6..D1.
// - I/O mode off: pin-level read returns the last written value.
// - Probe status register reads all eight bits of chosen probe bus.
// - Self-test register resets to 40h; fields at 6, 4, 3..0; 7,5 reserved.
// - Drive enable register resets to 80h: UART lines on, drivers off.
// - Check code 1001b enables digital self-test; 0000b is normal.

package tpc_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] TPC_OFS_BUS_PRBS  = 8'h32;
	localparam logic [7:0] TPC_OFS_PIN_EN    = 8'h33;
	localparam logic [7:0] TPC_OFS_PIN_LEVEL = 8'h34;
	localparam logic [7:0] TPC_OFS_PROBE     = 8'h35;
	localparam logic [7:0] TPC_OFS_DIGITAL_CHECK_CODE  = 8'h36;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] TPC_RST_BUS_PRBS  = 8'h00;
	localparam logic [7:0] TPC_RST_PIN_EN    = 8'h80;
	localparam logic [7:0] TPC_RST_PIN_LEVEL = 8'h00;
	localparam logic [7:0] TPC_RST_DIGITAL_CHECK_CODE  = 8'h40;

	// ************************************************************
	// Field positions and masks
	// ************************************************************
	localparam int TPC_BIT_SWAP       = 7;
	localparam int TPC_BIT_NINE_STAGE_PRBS_ENABLE      = 6;
	localparam int TPC_BIT_FIFTEEN_STAGE_PRBS_ENABLE     = 5;
	localparam int TPC_SEL_MSB        = 4;
	localparam int TPC_BIT_UART_EN    = 7;
	localparam int TPC_BIT_IO_MODE    = 7;
	localparam int TPC_PIN_MSB        = 6;
	localparam int TPC_PIN_LSB        = 1;
	localparam int TPC_BIT_NONLIN     = 6;
	localparam int TPC_BIT_FRAME_ADJ  = 4;
	localparam int TPC_CODE_MSB       = 3;
	// Writable bits, plus bit 7 of the pin registers; all others are reserved
	localparam logic [7:0] TPC_MASK_PIN     = 8'h7e;
	localparam logic [7:0] TPC_MASK_DIGITAL_CHECK_CODE = 8'h5f;
	// Pins usable on the SPI or UART-with-lines host: D1..D4
	localparam logic [6:1] TPC_LOW_PINS     = 6'h0f;

	// ************************************************************
	// Codes and PRBS structure
	// ************************************************************
	localparam logic [3:0] TPC_CODE_CHECK_ON = 4'h9;
	localparam logic [3:0] TPC_CODE_NORMAL   = 4'h0;
	localparam logic [14:0] TPC_PRBS_SEED    = 15'h7fff;
	localparam int TPC_P9_TAP_A  = 8;
	localparam int TPC_P9_TAP_B  = 4;
	localparam int TPC_P15_TAP_A = 14;
	localparam int TPC_P15_TAP_B = 13;

	// Sequence generator states
	typedef enum logic [1:0] {
		TPC_IDLE,
		TPC_RUN9,
		TPC_RUN15
	} tpc_prbs_state_t;

endpackage : tpc_pkg

// ---- core/tpc_probe_mux.sv ----
// Purpose: Picks one 8-bit probe group out of 32 and registers it.
// Assumes: Probe groups are synchronous to clk_in.
// Notes:   Output lags the select by one clock.

`timescale 1ns/100ps
`default_nettype none

module tpc_probe_mux
	import tpc_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	// Selection
	input  wire logic [4:0]   sel_in,
	input  wire logic [255:0] groups_in,
	// Chosen group
	output logic      [7:0]   probe_out
);

	logic [7:0] base;

	// Bit offset of the chosen group
	assign base = {sel_in, 3'h0};

	// ************************************************************
	// Registered selection
	// ************************************************************
	// Registering here breaks the long path from the probe sources
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			probe_out <= 8'h00;
		end else begin
			probe_out <= groups_in[base +: 8];
		end
	end

endmodule : tpc_probe_mux

`default_nettype wire

// ---- core/tpc_test_port.sv ----
// Purpose: Test-select, pin drive, pin I/O, probe status and self-test
//          control registers, with the two PRBS pattern generators.
// Assumes: Single clock, synchronous reset, pins synchronous to clk_in.
// Notes:   Register reads answer one cycle after the read strobe.

`timescale 1ns/100ps
`default_nettype none

module tpc_test_port
	import tpc_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	// Register bus
	input  wire logic [7:0]   addr_in,
	input  wire logic [7:0]   wdata_in,
	input  wire logic         wr_in,
	input  wire logic         rd_in,
	output logic      [7:0]   rdata_out,
	// Host interface in use
	input  wire logic         host_spi_in,
	input  wire logic         host_uart_in,
	// Probe sources, 32 groups of 8 bits
	input  wire logic [255:0] probe_groups_in,
	// Transmitter handshake
	input  wire logic         transmit_cmd_in,
	input  wire logic         transmit_stop_in,
	output logic              nine_stage_prbs_enable_out,
	output logic              fifteen_stage_prbs_enable_out,
	output logic              prbs_active_out,
	output logic              prbs_bit_out,
	// Parallel port view of the probe bus
	output logic      [7:0]   parallel_port_out,
	// Data pins D6..D1
	input  wire logic [6:1]   pin_in,
	output logic      [6:1]   pin_out,
	output logic      [6:1]   pin_oe_n_out,
	// UART auxiliary lines
	output logic              uart_line_enable_out,
	// Self-test and receiver controls
	output logic              receiver_nonlinear_processing_out,
	output logic              frame_delimiter_length_adjust_out,
	output logic      [3:0]   digital_check_code_out,
	output logic              digital_check_enable_out
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]      bus_prbs;
	logic [7:0]      pin_en;
	logic [7:0]      pin_level;
	logic [7:0]      digital_check_code;
	logic [7:0]      internal_probe_bus;
	logic [7:0]      next_port;
	logic [7:0]      next_rdata;
	logic [6:1]      usable;
	logic [6:1]      next_drive;
	logic [6:1]      next_level;
	logic            io_mode;
	logic            serial_host;
	logic            bus_order_swap;
	logic            nine_stage_prbs_enable;
	logic            fifteen_stage_prbs_enable;
	logic [4:0]      probe_group_select;
	logic            uart_line_enable;
	logic [14:0]     lfsr;
	logic            fb9;
	logic            fb15;
	tpc_prbs_state_t prbs_state;
	tpc_prbs_state_t next_prbs_state;

	// Field views
	assign bus_order_swap            = bus_prbs[TPC_BIT_SWAP];
	assign nine_stage_prbs_enable    = bus_prbs[TPC_BIT_NINE_STAGE_PRBS_ENABLE];
	assign fifteen_stage_prbs_enable = bus_prbs[TPC_BIT_FIFTEEN_STAGE_PRBS_ENABLE];
	assign probe_group_select        = bus_prbs[TPC_SEL_MSB:0];
	assign uart_line_enable          = pin_en[TPC_BIT_UART_EN];
	assign io_mode                   = pin_level[TPC_BIT_IO_MODE];
	assign serial_host               = host_spi_in | host_uart_in;

	// ************************************************************
	// Probe group selection
	// ************************************************************
	tpc_probe_mux u_probe_mux (
		.clk_in    (clk_in),
		.srst_in   (srst_in),
		.sel_in    (probe_group_select),
		.groups_in (probe_groups_in),
		.probe_out (internal_probe_bus)
	);

	// ************************************************************
	// Control registers
	// ************************************************************
	// Test-select and PRBS arm register, fully writable
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			bus_prbs <= TPC_RST_BUS_PRBS;
		end else if (wr_in && addr_in == TPC_OFS_BUS_PRBS) begin
			bus_prbs <= wdata_in;
		end
	end

	// Drive enable register; bit 0 stays zero
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_en <= TPC_RST_PIN_EN;
		end else if (wr_in && addr_in == TPC_OFS_PIN_EN) begin
			pin_en <= wdata_in & (TPC_MASK_PIN | 8'h80);
		end
	end

	// Pin level register; bit 0 stays zero
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_level <= TPC_RST_PIN_LEVEL;
		end else if (wr_in && addr_in == TPC_OFS_PIN_LEVEL) begin
			pin_level <= wdata_in & (TPC_MASK_PIN | 8'h80);
		end
	end

	// Self-test register; bits 7 and 5 stay zero
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			digital_check_code <= TPC_RST_DIGITAL_CHECK_CODE;
		end else if (wr_in && addr_in == TPC_OFS_DIGITAL_CHECK_CODE) begin
			digital_check_code <= wdata_in & TPC_MASK_DIGITAL_CHECK_CODE;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Unmapped offsets read as zero; data stand only in the next cycle
	always_comb begin
		next_rdata = 8'h00;
		unique case (addr_in)
			TPC_OFS_BUS_PRBS: begin
				next_rdata = bus_prbs;
			end
			TPC_OFS_PIN_EN: begin
				next_rdata = pin_en;
			end
			TPC_OFS_PIN_LEVEL: begin
				if (io_mode) begin
					next_rdata = {1'b1, pin_in, 1'b0};
				end else begin
					next_rdata = pin_level;
				end
			end
			TPC_OFS_PROBE: begin
				next_rdata = internal_probe_bus;
			end
			TPC_OFS_DIGITAL_CHECK_CODE: begin
				next_rdata = digital_check_code;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			rdata_out <= next_rdata;
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ************************************************************
	// Parallel port ordering
	// ************************************************************
	// Swapped order places the listed probe bits on port bits 6..0
	always_comb begin
		if (bus_order_swap) begin
			next_port = {internal_probe_bus[7],
				internal_probe_bus[4], internal_probe_bus[3],
				internal_probe_bus[2], internal_probe_bus[6],
				internal_probe_bus[5], internal_probe_bus[0],
				internal_probe_bus[1]};
		end else begin
			next_port = internal_probe_bus;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			parallel_port_out <= 8'h00;
		end else begin
			parallel_port_out <= next_port;
		end
	end

	// ************************************************************
	// Pin drivers
	// ************************************************************
	// The host interface claims D5 and D6 on SPI, or UART with lines on
	always_comb begin
		if (host_spi_in) begin
			usable = TPC_LOW_PINS;
		end else if (host_uart_in && uart_line_enable) begin
			usable = TPC_LOW_PINS;
		end else begin
			usable = 6'h3f;
		end
	end

	// Enabled pins carry the port bit, or the level bit in I/O mode with a serial host
	assign next_drive = pin_en[TPC_PIN_MSB:TPC_PIN_LSB] & usable;
	always_comb begin
		if (io_mode && serial_host) begin
			next_level = pin_level[TPC_PIN_MSB:TPC_PIN_LSB];
		end else begin
			next_level = next_port[TPC_PIN_MSB:TPC_PIN_LSB];
		end
	end

	// Output enable is low while a pin is driven
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_out      <= 6'h00;
			pin_oe_n_out <= 6'h3f;
		end else begin
			pin_out      <= next_level & next_drive;
			pin_oe_n_out <= ~next_drive;
		end
	end

	// ************************************************************
	// Plain control outputs
	// ************************************************************
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			uart_line_enable_out              <= 1'b1;
			receiver_nonlinear_processing_out <= 1'b1;
			frame_delimiter_length_adjust_out <= 1'b0;
			digital_check_code_out            <= TPC_CODE_NORMAL;
			digital_check_enable_out          <= 1'b0;
			nine_stage_prbs_enable_out        <= 1'b0;
			fifteen_stage_prbs_enable_out     <= 1'b0;
		end else begin
			uart_line_enable_out              <= uart_line_enable;
			receiver_nonlinear_processing_out <= digital_check_code[TPC_BIT_NONLIN];
			frame_delimiter_length_adjust_out <= digital_check_code[TPC_BIT_FRAME_ADJ];
			digital_check_code_out            <= digital_check_code[TPC_CODE_MSB:0];
			digital_check_enable_out          <=
				(digital_check_code[TPC_CODE_MSB:0] == TPC_CODE_CHECK_ON);
			nine_stage_prbs_enable_out        <= nine_stage_prbs_enable;
			fifteen_stage_prbs_enable_out     <= fifteen_stage_prbs_enable;
		end
	end

	// ************************************************************
	// PRBS sequencer
	// ************************************************************
	// Arming alone sends nothing; the Transmit command starts a pattern.
	// Nine-stage wins if software arms both, since only one can run.
	always_comb begin
		next_prbs_state = prbs_state;
		unique case (prbs_state)
			TPC_IDLE: begin
				if (transmit_cmd_in && nine_stage_prbs_enable) begin
					next_prbs_state = TPC_RUN9;
				end else if (transmit_cmd_in && fifteen_stage_prbs_enable) begin
					next_prbs_state = TPC_RUN15;
				end
			end
			TPC_RUN9: begin
				if (transmit_stop_in || !nine_stage_prbs_enable) begin
					next_prbs_state = TPC_IDLE;
				end
			end
			TPC_RUN15: begin
				if (transmit_stop_in || !fifteen_stage_prbs_enable) begin
					next_prbs_state = TPC_IDLE;
				end
			end
			default: begin
				next_prbs_state = TPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prbs_state <= TPC_IDLE;
		end else begin
			prbs_state <= next_prbs_state;
		end
	end

	// Feedback taps: x^9+x^5+1 and x^15+x^14+1
	assign fb9  = lfsr[TPC_P9_TAP_A] ^ lfsr[TPC_P9_TAP_B];
	assign fb15 = lfsr[TPC_P15_TAP_A] ^ lfsr[TPC_P15_TAP_B];

	// Register reseeds while idle so every run starts identically
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lfsr            <= TPC_PRBS_SEED;
			prbs_bit_out    <= 1'b0;
			prbs_active_out <= 1'b0;
		end else begin
			prbs_active_out <= (next_prbs_state != TPC_IDLE);
			unique case (prbs_state)
				TPC_RUN9: begin
					lfsr         <= {lfsr[14:9], lfsr[7:0], fb9};
					prbs_bit_out <= fb9;
				end
				TPC_RUN15: begin
					lfsr         <= {lfsr[13:0], fb15};
					prbs_bit_out <= fb15;
				end
				default: begin
					lfsr         <= TPC_PRBS_SEED;
					prbs_bit_out <= 1'b0;
				end
			endcase
		end
	end

endmodule : tpc_test_port

`default_nettype wire

// ---- testbench/tpc_test_port_chk.sv ----
// Purpose: Port-level checks of the test port block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Writes are judged two cycles on, which covers both latencies.
`timescale 1ns/100ps
`default_nettype none
module tpc_test_port_chk
	import tpc_pkg::*;
(
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       srst_in,
	// Register bus
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       rd_in,
	input wire logic       wr_in,
	input wire logic [7:0] rdata_out,
	// Host, pattern and pin side
	input wire logic       host_spi_in,
	input wire logic       transmit_cmd_in,
	input wire logic       transmit_stop_in,
	input wire logic       nine_stage_prbs_enable_out,
	input wire logic       prbs_active_out,
	input wire logic       prbs_bit_out,
	input wire logic [6:1] pin_oe_n_out,
	input wire logic       uart_line_enable_out,
	input wire logic       receiver_nonlinear_processing_out,
	input wire logic       digital_check_enable_out
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	AST_RST_STATE: assert property ($fell(srst_in) |-> rdata_out == 8'h00
		&& pin_oe_n_out == 6'h3f && uart_line_enable_out
		&& receiver_nonlinear_processing_out && !prbs_active_out)
		else $error("state after reset wrong");
	AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data without read");
	AST_UART_EN: assert property (wr_in && addr_in == 8'h33
		##1 !(wr_in && addr_in == 8'h33)
		|=> uart_line_enable_out == $past(wdata_in[7], 2))
		else $error("uart line enable not following write");
	AST_ARM9: assert property (wr_in && addr_in == 8'h32
		##1 !(wr_in && addr_in == 8'h32)
		|=> nine_stage_prbs_enable_out == $past(wdata_in[6], 2))
		else $error("nine stage arm not following write");
	AST_CHECK_ON: assert property (wr_in && addr_in == 8'h36
		##1 !(wr_in && addr_in == 8'h36)
		|=> digital_check_enable_out == ($past(wdata_in[3:0], 2) == 4'h9))
		else $error("self-test enable wrong for code");
	AST_START: assert property ($rose(prbs_active_out) |-> $past(transmit_cmd_in))
		else $error("pattern started without command");
	AST_STOP: assert property (prbs_active_out && transmit_stop_in |=> !prbs_active_out)
		else $error("pattern did not stop");
	AST_IDLE_BIT: assert property (!prbs_active_out && !$past(prbs_active_out)
		|-> !prbs_bit_out)
		else $error("pattern bit while idle");
	AST_SPI_PINS: assert property (host_spi_in && $past(host_spi_in)
		|-> pin_oe_n_out[6:5] == 2'b11)
		else $error("high pin driven with spi host");
endmodule : tpc_test_port_chk

bind tpc_test_port tpc_test_port_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .rd_in(rd_in), .wr_in(wr_in),
	.rdata_out(rdata_out), .host_spi_in(host_spi_in),
	.transmit_cmd_in(transmit_cmd_in), .transmit_stop_in(transmit_stop_in),
	.nine_stage_prbs_enable_out(nine_stage_prbs_enable_out),
	.prbs_active_out(prbs_active_out), .prbs_bit_out(prbs_bit_out),
	.pin_oe_n_out(pin_oe_n_out), .uart_line_enable_out(uart_line_enable_out),
	.receiver_nonlinear_processing_out(receiver_nonlinear_processing_out),
	.digital_check_enable_out(digital_check_enable_out));
`default_nettype wire

// ---- testbench/tpc_test_port_test.sv ----
// Purpose: Self-checking bench for the test port block.
// Assumes: 50 MHz clock, seeded random stimulus.
// Notes:   Expected values come from bench functions only.
`timescale 1ns/100ps
`default_nettype none
module tpc_test_port_test
	import tpc_pkg::*;
;
	logic         clk_in, srst_in, wr_in, rd_in, spi, uart, cmd, stop;
	logic [7:0]   addr_in, wdata_in, rdata_out, port;
	logic [255:0] groups;
	logic [6:1]   pin_in, pin_out, pin_oe_n;
	logic         p9, p15, act, pbit, uart_en, nonlin, adj, chk_en;
	logic [3:0]   code;
	int           num_errors, n_checks, cycles;

	// Clock at 20 ns
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	tpc_test_port u_dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.host_spi_in(spi), .host_uart_in(uart), .probe_groups_in(groups),
		.transmit_cmd_in(cmd), .transmit_stop_in(stop),
		.nine_stage_prbs_enable_out(p9), .fifteen_stage_prbs_enable_out(p15),
		.prbs_active_out(act), .prbs_bit_out(pbit), .parallel_port_out(port),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n),
		.uart_line_enable_out(uart_en), .receiver_nonlinear_processing_out(nonlin),
		.frame_delimiter_length_adjust_out(adj), .digital_check_code_out(code),
		.digital_check_enable_out(chk_en));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s saw %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	// One-cycle strobes, changed just after the edge
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : reg_rd

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_clk

	task automatic pulse(input logic is_stop);
		@(posedge clk_in);
		cmd  <= !is_stop;
		stop <= is_stop;
		@(posedge clk_in);
		cmd  <= 1'b0;
		stop <= 1'b0;
		#1;
	endtask : pulse

	// Permuted order of the probe bus on the parallel port
	function automatic logic [7:0] swap(input logic [7:0] b);
		return {b[7], b[4], b[3], b[2], b[6], b[5], b[0], b[1]};
	endfunction : swap

	// Arms one pattern, then checks its recurrence over 40 bits
	task automatic prbs_run(input logic [7:0] arm, input int a, input int b);
		logic bits [40];
		logic ok;
		logic any;
		ok  = 1'b1;
		any = 1'b0;
		reg_wr(8'h32, arm);
		wait_clk(2);
		check(p9, arm[6], "arm 9");
		check(p15, arm[5], "arm 15");
		pulse(1'b0);
		check(act, 1'b1, "pattern start");
		for (int i = 0; i < 40; i++) begin
			wait_clk(1);
			bits[i] = pbit;
			any |= pbit;
		end
		for (int i = a; i < 40; i++) begin
			if (bits[i] !== (bits[i - a] ^ bits[i - b])) ok = 1'b0;
		end
		check({ok, any}, 2'b11, "pattern sequence");
		pulse(1'b1);
		check(act, 1'b0, "pattern stop");
	endtask : prbs_run

	// Hang guard
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		logic [7:0] d, w, en, lvl;
		logic [4:0] sel;
		int         k;
		void'($urandom(8862));
		{srst_in, wr_in, rd_in, spi, uart, cmd, stop} = 7'h40;
		{addr_in, wdata_in, pin_in} = '0;
		for (int i = 0; i < 8; i++) groups[32*i +: 32] = $urandom;
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		reg_rd(8'h32, d);
		check(d, 8'h00, "reset select");
		reg_rd(8'h33, d);
		check(d, 8'h80, "reset enables");
		reg_rd(8'h36, d);
		check(d, 8'h40, "reset self-test");
		reg_rd(8'h37, d);
		check(d, 8'h00, "unmapped");
		check(uart_en, 1'b1, "uart lines");
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			w = 8'($urandom);
			reg_wr(8'h33, w);
			reg_rd(8'h33, d);
			check(d, w & 8'hfe, "enables");
			reg_wr(8'h34, w & 8'h7f);
			reg_rd(8'h34, d);
			check(d, w & 8'h7e, "stored level");
			reg_wr(8'h36, w);
			reg_rd(8'h36, d);
			check(d, w & 8'h5f, "self-test");
		end
		$display("readback test done");
		for (int i = 0; i < 8; i++) begin
			w = 8'($urandom);
			sel = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : w[4:0];
			k = 8 * int'(sel);
			reg_wr(8'h32, {w[7], 2'b00, sel});
			reg_wr(8'h35, 8'hff);
			wait_clk(3);
			reg_rd(8'h35, d);
			check(d, groups[k +: 8], "probe bus");
			check(port, w[7] ? swap(groups[k +: 8]) : groups[k +: 8], "port");
		end
		$display("probe test done");
		reg_wr(8'h36, 8'h49);
		wait_clk(2);
		check({chk_en, code, nonlin, adj}, 7'h66, "code on");
		reg_wr(8'h36, 8'h10);
		wait_clk(2);
		check({chk_en, code, nonlin, adj}, 7'h01, "code off");
		$display("self-test test done");
		uart <= 1'b1;
		en = 8'($urandom) | 8'h62;
		lvl = 8'($urandom);
		w = 8'($urandom);
		pin_in <= w[6:1];
		reg_wr(8'h33, {1'b0, en[6:1], 1'b0});
		reg_wr(8'h34, {1'b1, lvl[6:1], 1'b0});
		wait_clk(3);
		check(pin_oe_n, 6'(~en[6:1]), "drivers");
		check(pin_out, lvl[6:1] & en[6:1], "levels");
		reg_rd(8'h34, d);
		check(d, {1'b1, w[6:1], 1'b0}, "live pins");
		reg_wr(8'h33, {1'b1, en[6:1], 1'b0});
		wait_clk(3);
		check(pin_oe_n, 6'(~(en[6:1] & 6'h0f)), "uart pins");
		uart <= 1'b0;
		spi  <= 1'b1;
		wait_clk(3);
		check(pin_oe_n, 6'(~(en[6:1] & 6'h0f)), "spi pins");
		$display("pin test done");
		prbs_run(8'h40, 9, 5);
		prbs_run(8'h20, 15, 14);
		reg_wr(8'h32, 8'h00);
		wait_clk(2);
		pulse(1'b0);
		check(act, 1'b0, "unarmed command");
		$display("pattern test done");
		report_and_stop();
	end
endmodule : tpc_test_port_test
`default_nettype wire
